// [rtl/dcp_clock_power.sv]
`timescale 1ns/10ps
`default_nettype none
module dcp_clock_power
  import dcp_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write channels
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // oscillators
  input  wire logic        fast_rc_osc_tick,
  input  wire logic        slow_rc_osc_tick,
  input  wire logic [6:0]  factory_trim_value,
  output logic             fast_osc_enable,
  output logic             slow_osc_enable,
  output logic [6:0]       fast_osc_trim,
  // wake-up sources
  input  wire logic        enabled_irq,
  input  wire logic        pin_wake,
  input  wire logic        timer3_irq,
  input  wire logic        timer3_enable,
  input  wire logic        watchdog_enable,
  input  wire logic [1:0]  external_irq_pin,
  input  wire logic [1:0]  external_irq_enable,
  // derived clocks and state
  output logic             sys_clk_tick,
  output logic             cpu_clk_tick,
  output logic             periph_clk_tick,
  output logic             timer3_clk_tick,
  output logic             watchdog_clk_tick,
  output logic             half_clock_output,
  output logic             bandgap_output_enable,
  output logic             cpu_sleeping,
  output logic             deep_sleep_state
);
  // ==========================================================
  // registers
  dcp_mode_type mode_reg;
  logic [7:0]   clock_control_reg;
  logic [7:0]   power_control_reg;
  logic [7:0]   option_select_reg;
  logic [6:0]   fast_osc_trim_reg;
  logic [7:0]   aux_control_two_reg;
  logic         trim_loaded_reg;
  logic [3:0]   div_count_reg;
  logic [1:0]   eff_psc_reg;
  logic         eff_fast_reg;
  logic [8:0]   t3_div_reg;
  logic [15:0]  aw_addr_reg;
  logic         aw_full_reg;
  logic [31:0]  w_data_reg;
  logic [3:0]   w_strb_reg;
  logic         w_full_reg;
  logic         do_write;
  logic [13:0]  w_idx;
  logic [13:0]  r_idx;
  logic [7:0]   wbyte;
  logic [7:0]   rd_byte;
  logic         rd_hit;
  logic         wr_hit;

  assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign w_idx    = aw_addr_reg[15:2];
  assign r_idx    = s_axi_araddr[15:2];
  assign wbyte    = w_data_reg[7:0];

  // ==========================================================
  // axi write path: address and data latched independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      aw_addr_reg   <= 16'h0000;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end else if (!aw_full_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg   <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end else if (!w_full_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    wr_hit = (aw_addr_reg[1:0] == 2'h0) &&
             (w_idx == IDX_POWER_CONTROL || w_idx == IDX_OPTION_SELECT ||
              w_idx == IDX_CLOCK_CONTROL || w_idx == IDX_FAST_OSC_TRIM ||
              w_idx == IDX_AUX_CONTROL_2);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // axi read path
  always_comb begin
    rd_hit  = (s_axi_araddr[1:0] == 2'h0);
    rd_byte = 8'h00;
    case (r_idx)
      IDX_POWER_CONTROL:  rd_byte = power_control_reg;
      IDX_OPTION_SELECT:  rd_byte = option_select_reg;
      IDX_CLOCK_CONTROL:  rd_byte = clock_control_reg;
      IDX_FAST_OSC_TRIM:  rd_byte = {1'b0, fast_osc_trim_reg};
      IDX_AUX_CONTROL_2:  rd_byte = aux_control_two_reg;
      IDX_CONFIG_WORD_LO: rd_byte = {1'b0, factory_trim_value};
      default:            rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // clock control register with hardware write guards
  logic cc_we;
  logic fast_stop_ok;
  logic fast_sel_ok;
  assign cc_we = do_write && w_strb_reg[0] && (w_idx == IDX_CLOCK_CONTROL);
  // the stop bit must not cut a fast clock the divider still runs on
  assign fast_stop_ok = ~clock_control_reg[CC_FAST_SEL] & ~eff_fast_reg;
  assign fast_sel_ok  = ~clock_control_reg[CC_FAST_STOP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_control_reg <= CLOCK_CONTROL_RESET;
    end else if (cc_we) begin
      clock_control_reg[CC_SLOW_STOP]   <= wbyte[CC_SLOW_STOP];
      clock_control_reg[CC_PERIPH_STOP] <= wbyte[CC_PERIPH_STOP];
      clock_control_reg[1:0]            <= wbyte[1:0];
      if (fast_stop_ok) begin
        clock_control_reg[CC_FAST_STOP] <= wbyte[CC_FAST_STOP];
      end
      if (fast_sel_ok) begin
        clock_control_reg[CC_FAST_SEL] <= wbyte[CC_FAST_SEL];
      end
    end
  end

  // ==========================================================
  // other registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_select_reg <= OPTION_RESET;
    end else if (do_write && w_strb_reg[0] && w_idx == IDX_OPTION_SELECT) begin
      option_select_reg <= wbyte & OPTION_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_control_two_reg <= AUXILIARY_CONTROL_TWO_RESET;
    end else if (do_write && w_strb_reg[0] && w_idx == IDX_AUX_CONTROL_2) begin
      aux_control_two_reg <= wbyte;
    end
  end

  // trim is captured on the first edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_loaded_reg   <= 1'b0;
      fast_osc_trim_reg <= 7'h00;
    end else if (!trim_loaded_reg) begin
      trim_loaded_reg   <= 1'b1;
      fast_osc_trim_reg <= factory_trim_value;
    end else if (do_write && w_strb_reg[0] && w_idx == IDX_FAST_OSC_TRIM) begin
      fast_osc_trim_reg <= wbyte[6:0];
    end
  end

  // ==========================================================
  // operating mode sequencer
  logic pc_we;
  logic irq_pin_blocks;
  assign pc_we          = do_write && w_strb_reg[0] && (w_idx == IDX_POWER_CONTROL);
  assign irq_pin_blocks = |(~external_irq_pin & external_irq_enable);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg          <= MODE_RUN;
      power_control_reg <= POWER_CONTROL_RESET;
    end else begin
      case (mode_reg)
        MODE_RUN: begin
          if (pc_we) begin
            power_control_reg <= wbyte & POWER_CONTROL_MASK;
            if (wbyte[PC_POWER_DOWN] && !irq_pin_blocks) begin
              mode_reg <= clock_control_reg[CC_SLOW_STOP] ?
                          MODE_STOP : MODE_HALT;
            end else if (wbyte[PC_POWER_DOWN]) begin
              power_control_reg[PC_POWER_DOWN] <= 1'b0;
              if (wbyte[PC_SLEEP]) begin
                mode_reg <= MODE_IDLE;
              end
            end else if (wbyte[PC_SLEEP]) begin
              mode_reg <= MODE_IDLE;
            end
          end
        end
        MODE_IDLE: begin
          if (enabled_irq || pin_wake) begin
            mode_reg                     <= MODE_RUN;
            power_control_reg[PC_SLEEP]  <= 1'b0;
          end
        end
        MODE_HALT: begin
          if (pin_wake || timer3_irq) begin
            mode_reg                          <= MODE_RUN;
            power_control_reg[1:0]            <= 2'h0;
          end
        end
        MODE_STOP: begin
          if (pin_wake) begin
            mode_reg               <= MODE_RUN;
            power_control_reg[1:0] <= 2'h0;
          end
        end
        default: begin
          mode_reg <= MODE_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // oscillator gating
  logic fast_run;
  logic slow_run;
  logic deep;
  assign deep     = (mode_reg == MODE_HALT) || (mode_reg == MODE_STOP);
  assign fast_run = ~clock_control_reg[CC_FAST_STOP] & ~deep;
  // watchdog keeps the slow oscillator alive even in stop
  assign slow_run = ~((mode_reg == MODE_STOP) & clock_control_reg[CC_SLOW_STOP]) |
                    watchdog_enable;

  // ==========================================================
  // glitch-free prescaler; settings reload only at a period boundary
  logic       src_tick;
  logic       sys_tick;
  logic [3:0] div_last;
  assign src_tick = eff_fast_reg ? (fast_rc_osc_tick & fast_run) :
                                   (slow_rc_osc_tick & slow_run);

  always_comb begin
    case (eff_psc_reg)
      PSC_DIV16: div_last = 4'hf;
      PSC_DIV4:  div_last = 4'h3;
      PSC_DIV2:  div_last = 4'h1;
      PSC_DIV1:  div_last = 4'h0;
      default:   div_last = 4'h0;
    endcase
  end

  assign sys_tick = src_tick && (div_count_reg >= div_last);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_count_reg <= 4'h0;
      eff_psc_reg   <= PSC_DIV1;
      eff_fast_reg  <= 1'b0;
    end else if (sys_tick) begin
      div_count_reg <= 4'h0;
      eff_psc_reg   <= clock_control_reg[1:0];
      eff_fast_reg  <= clock_control_reg[CC_FAST_SEL];
    end else if (src_tick) begin
      div_count_reg <= div_count_reg + 4'h1;
    end
  end

  // ==========================================================
  // timer3 source: fast divided by 512 when OS_TIMER3_SEL is set, otherwise slow; slow in halt, none in stop
  logic t3_fast_tick;
  logic t3_tick;
  assign t3_fast_tick = fast_rc_osc_tick & fast_run & (t3_div_reg == 9'h1ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t3_div_reg <= 9'h000;
    end else if (fast_rc_osc_tick && fast_run) begin
      t3_div_reg <= t3_div_reg + 9'h001;
    end
  end

  always_comb begin
    t3_tick = 1'b0;
    if (timer3_enable && mode_reg != MODE_STOP) begin
      if (mode_reg == MODE_HALT || !option_select_reg[OS_TIMER3_SEL]) begin
        t3_tick = slow_rc_osc_tick & slow_run;
      end else begin
        t3_tick = t3_fast_tick;
      end
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk_tick      <= 1'b0;
      cpu_clk_tick      <= 1'b0;
      periph_clk_tick   <= 1'b0;
      timer3_clk_tick   <= 1'b0;
      watchdog_clk_tick <= 1'b0;
    end else begin
      sys_clk_tick      <= sys_tick;
      cpu_clk_tick      <= sys_tick & (mode_reg == MODE_RUN);
      periph_clk_tick   <= sys_tick & ((mode_reg == MODE_RUN) ||
                           (mode_reg == MODE_IDLE &&
                            !clock_control_reg[CC_PERIPH_STOP]));
      timer3_clk_tick   <= t3_tick;
      watchdog_clk_tick <= slow_rc_osc_tick & slow_run & watchdog_enable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_clock_output <= 1'b0;
    end else if (sys_tick) begin
      half_clock_output <= ~half_clock_output;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_osc_enable       <= 1'b1;
      slow_osc_enable       <= 1'b1;
      fast_osc_trim         <= 7'h00;
      bandgap_output_enable <= 1'b0;
      cpu_sleeping          <= 1'b0;
      deep_sleep_state      <= 1'b0;
    end else begin
      fast_osc_enable       <= fast_run;
      slow_osc_enable       <= slow_run;
      fast_osc_trim         <= fast_osc_trim_reg;
      bandgap_output_enable <= aux_control_two_reg[AUX_BANDGAP];
      cpu_sleeping          <= (mode_reg != MODE_RUN);
      deep_sleep_state      <= deep;
    end
  end
endmodule : dcp_clock_power
`default_nettype wire

// [include/dcp_pkg.sv]
package dcp_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [13:0] IDX_POWER_CONTROL  = 14'h0087;
  localparam logic [13:0] IDX_OPTION_SELECT  = 14'h0094;
  localparam logic [13:0] IDX_CLOCK_CONTROL  = 14'h00d8;
  localparam logic [13:0] IDX_FAST_OSC_TRIM  = 14'h00f6;
  localparam logic [13:0] IDX_AUX_CONTROL_2  = 14'h00f7;
  localparam logic [13:0] IDX_CONFIG_WORD_LO = 14'h3ffd;
  // ==========================================================
  // field positions
  localparam int CC_SLOW_STOP   = 5;
  localparam int CC_PERIPH_STOP = 4;
  localparam int CC_FAST_STOP   = 3;
  localparam int CC_FAST_SEL    = 2;
  localparam int PC_POWER_DOWN  = 1;
  localparam int PC_SLEEP       = 0;
  localparam int OS_TIMER3_SEL  = 6;
  localparam int AUX_BANDGAP    = 4;
  // ==========================================================
  // reset values and masks
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h23;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET        = 8'h00;
  localparam logic [7:0] AUXILIARY_CONTROL_TWO_RESET          = 8'h06;
  localparam logic [7:0] POWER_CONTROL_MASK  = 8'h8f;
  localparam logic [7:0] OPTION_MASK         = 8'h7c;
  localparam logic [7:0] CLOCK_CONTROL_MASK  = 8'h3f;
  localparam logic [7:0] TRIM_MASK           = 8'h7f;
  // ==========================================================
  // clock figures
  localparam int FAST_OSC_KHZ      = 18432;
  localparam int SLOW_OSC_KHZ      = 75;
  localparam int PRESCALE_MAX_CYC  = 16;
  localparam int TIMER3_FAST_DIV   = 512;
  localparam logic [1:0] PSC_DIV16 = 2'h0;
  localparam logic [1:0] PSC_DIV4  = 2'h1;
  localparam logic [1:0] PSC_DIV2  = 2'h2;
  localparam logic [1:0] PSC_DIV1  = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  typedef enum logic [3:0] {
    MODE_RUN  = 4'b0001,
    MODE_IDLE = 4'b0010,
    MODE_HALT = 4'b0100,
    MODE_STOP = 4'b1000
  } dcp_mode_type;
endpackage : dcp_pkg

// [verification/dcp_clock_power_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module dcp_checker (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // oscillator and wake inputs
  input wire logic       fast_rc_osc_tick,
  input wire logic       slow_rc_osc_tick,
  input wire logic [6:0] factory_trim_value,
  input wire logic       watchdog_enable,
  input wire logic [1:0] external_irq_pin,
  input wire logic [1:0] external_irq_enable,
  // watched outputs
  input wire logic       fast_osc_enable,
  input wire logic [6:0] fast_osc_trim,
  input wire logic       sys_clk_tick,
  input wire logic       cpu_clk_tick,
  input wire logic       periph_clk_tick,
  input wire logic       timer3_clk_tick,
  input wire logic       watchdog_clk_tick,
  input wire logic       half_clock_output,
  input wire logic       cpu_sleeping,
  input wire logic       deep_sleep_state
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // sequences
  sequence s_release;
    $rose(aresetn);
  endsequence
  sequence s_deep_held;
    deep_sleep_state && $past(deep_sleep_state);
  endsequence
  // ==========================================================
  // properties
  // trim reaches the register one edge after release and the pin one edge later
  a_trim_load: assert property (s_release |-> ##2 fast_osc_trim == factory_trim_value)
    else $error("trim not loaded after reset");
  a_sys_source: assert property (sys_clk_tick |->
    $past(fast_rc_osc_tick || slow_rc_osc_tick))
    else $error("system tick without source tick");
  a_cpu_run_only: assert property (cpu_clk_tick |-> sys_clk_tick && !cpu_sleeping)
    else $error("cpu tick outside run mode");
  a_periph_follows: assert property (periph_clk_tick |->
    sys_clk_tick && !deep_sleep_state)
    else $error("peripheral tick without system tick");
  a_half_clock: assert property ($changed(half_clock_output) |->
    $past(sys_clk_tick) || sys_clk_tick)
    else $error("half clock moved without system tick");
  // mode is decided two edges before the state output shows it
  a_pd_blocked: assert property ($rose(deep_sleep_state) |->
    $past((~external_irq_pin & external_irq_enable) == 2'h0, 2))
    else $error("power down entered with low enabled pin");
  a_fast_off_deep: assert property (s_deep_held |-> !fast_osc_enable && cpu_sleeping)
    else $error("fast oscillator running in power down");
  a_timer3_halt: assert property (s_deep_held ##0 timer3_clk_tick |->
    $past(slow_rc_osc_tick))
    else $error("timer3 tick in halt not from slow source");
  a_watchdog_src: assert property (watchdog_clk_tick |->
    $past(slow_rc_osc_tick && watchdog_enable))
    else $error("watchdog tick without enabled slow tick");
endmodule : dcp_checker
bind dcp_clock_power dcp_checker chk_u (.aclk, .aresetn, .fast_rc_osc_tick, .slow_rc_osc_tick,
  .factory_trim_value, .watchdog_enable, .external_irq_pin, .external_irq_enable, .fast_osc_enable,
  .fast_osc_trim, .sys_clk_tick, .cpu_clk_tick, .periph_clk_tick, .timer3_clk_tick,
  .watchdog_clk_tick, .half_clock_output, .cpu_sleeping, .deep_sleep_state);
`default_nettype wire

// [verification/dcp_clock_power_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module dcp_clock_power_bench import dcp_pkg::*;;
  // ==========================================================
  // stimulus and observed signals
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        fast_rc_osc_tick = 1'h0, slow_rc_osc_tick = 1'h0;
  logic [6:0]  factory_trim_value = 7'h5a, fast_osc_trim;
  logic        enabled_irq = 1'h0, pin_wake = 1'h0, timer3_irq = 1'h0;
  logic        timer3_enable = 1'h1, watchdog_enable = 1'h0;
  logic [1:0]  external_irq_pin = 2'h3, external_irq_enable = 2'h0;
  logic        fast_osc_enable, slow_osc_enable, sys_clk_tick, cpu_clk_tick, periph_clk_tick;
  logic        timer3_clk_tick, watchdog_clk_tick, half_clock_output, bandgap_output_enable;
  logic        cpu_sleeping, deep_sleep_state;
  logic [2:0]  phase = 3'h0;
  int          err_count = 0, comparisons = 0, cycles = 0;
  int          n_sys, n_cpu, n_per, n_t3, n_wd;
  bit          count_en = 1'b0;
  int          divs[4] = '{16, 4, 2, 1};

  dcp_clock_power dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fast_rc_osc_tick, .slow_rc_osc_tick, .factory_trim_value,
    .fast_osc_enable, .slow_osc_enable, .fast_osc_trim, .enabled_irq, .pin_wake, .timer3_irq,
    .timer3_enable, .watchdog_enable, .external_irq_pin, .external_irq_enable, .sys_clk_tick,
    .cpu_clk_tick, .periph_clk_tick, .timer3_clk_tick, .watchdog_clk_tick, .half_clock_output,
    .bandgap_output_enable, .cpu_sleeping, .deep_sleep_state);

  always #50 aclk = ~aclk;

  // ==========================================================
  // oscillators: fast every 2 cycles, slow every 8; tick counters
  always @(posedge aclk) begin
    phase <= phase + 3'h1;
    fast_rc_osc_tick <= phase[0];
    slow_rc_osc_tick <= (phase == 3'h7);
    if (count_en) begin
      n_sys += sys_clk_tick;
      n_cpu += cpu_clk_tick;
      n_per += periph_clk_tick;
      n_t3 += timer3_clk_tick;
      n_wd += watchdog_clk_tick;
    end
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] resp);
    logic done;
    done = 1'h0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      // bready stays high, so a following call never drives it twice in one step
      if (s_axi_bvalid === 1'h1) begin
        done = 1'h1;
        chk("bresp", {30'h0, resp}, {30'h0, s_axi_bresp});
      end
    end
  endtask : wr

  task automatic rd(input string nm, input logic [13:0] idx, input logic [7:0] exp,
                    input logic [1:0] resp);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    chk(nm, {24'h0, exp}, s_axi_rdata);
    chk("rresp", {30'h0, resp}, {30'h0, s_axi_rresp});
  endtask : rd

  task automatic ck(input int n);
    repeat (n) @(posedge aclk);
  endtask : ck

  // counts ticks over n edges; the gate moves off the edge to avoid a race
  task automatic measure(input int n);
    @(negedge aclk);
    n_sys = 0;
    n_cpu = 0;
    n_per = 0;
    n_t3 = 0;
    n_wd = 0;
    count_en = 1'b1;
    repeat (n) @(negedge aclk);
    count_en = 1'b0;
    @(posedge aclk);
  endtask : measure

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // ==========================================================
  // tests
  initial begin
    ck(4);
    aresetn <= 1'h1;
    ck(2);
    rd("clock_control", IDX_CLOCK_CONTROL, 8'h23, RESP_OKAY);
    rd("power_control", IDX_POWER_CONTROL, 8'h00, RESP_OKAY);
    rd("option_select", IDX_OPTION_SELECT, 8'h00, RESP_OKAY);
    rd("aux_control", IDX_AUX_CONTROL_2, 8'h06, RESP_OKAY);
    rd("trim", IDX_FAST_OSC_TRIM, 8'h5a, RESP_OKAY);
    rd("config_word", IDX_CONFIG_WORD_LO, 8'h5a, RESP_OKAY);
    rd("unmapped", 14'h0010, 8'h00, RESP_SLVERR);
    wr(IDX_CONFIG_WORD_LO, 8'h11, RESP_SLVERR);
    chk("trim_out", 32'h5a, fast_osc_trim);
    wr(IDX_FAST_OSC_TRIM, 8'h7f, RESP_OKAY);
    ck(2);
    chk("trim_out", 32'h7f, fast_osc_trim);
    wr(IDX_FAST_OSC_TRIM, 8'h00, RESP_OKAY);
    ck(2);
    chk("trim_out", 32'h00, fast_osc_trim);
    wr(IDX_AUX_CONTROL_2, 8'h16, RESP_OKAY);
    ck(2);
    chk("bandgap", 32'h1, bandgap_output_enable);
    wr(IDX_AUX_CONTROL_2, 8'h06, RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CLOCK_CONTROL, 8'h20 | i[7:0], RESP_OKAY);
      ck(140);
      measure(256);
      chk("sys_ticks", 32 / divs[i], n_sys);
    end
    $display("test prescaler done");
    // the long settle after the write covers the prescaler wait before going fast
    wr(IDX_CLOCK_CONTROL, 8'h27, RESP_OKAY);
    ck(140);
    measure(256);
    chk("fast_ticks", 32'd128, n_sys);
    wr(IDX_CLOCK_CONTROL, 8'h2b, RESP_OKAY);
    rd("clock_control", IDX_CLOCK_CONTROL, 8'h23, RESP_OKAY);
    ck(140);
    wr(IDX_CLOCK_CONTROL, 8'h2b, RESP_OKAY);
    rd("clock_control", IDX_CLOCK_CONTROL, 8'h2b, RESP_OKAY);
    ck(2);
    chk("fast_enable", 32'h0, fast_osc_enable);
    wr(IDX_CLOCK_CONTROL, 8'h27, RESP_OKAY);
    rd("clock_control", IDX_CLOCK_CONTROL, 8'h23, RESP_OKAY);
    $display("test source guards done");
    wr(IDX_CLOCK_CONTROL, 8'h33, RESP_OKAY);
    wr(IDX_POWER_CONTROL, 8'h01, RESP_OKAY);
    ck(2);
    chk("sleeping", 32'h1, cpu_sleeping);
    measure(64);
    chk("sys_ticks", 32'd8, n_sys);
    chk("cpu_ticks", 32'd0, n_cpu);
    chk("periph_ticks", 32'd0, n_per);
    enabled_irq <= 1'h1;
    ck(3);
    chk("sleeping", 32'h0, cpu_sleeping);
    enabled_irq <= 1'h0;
    rd("power_control", IDX_POWER_CONTROL, 8'h00, RESP_OKAY);
    $display("test idle done");
    external_irq_pin <= 2'h2;
    external_irq_enable <= 2'h1;
    wr(IDX_POWER_CONTROL, 8'h02, RESP_OKAY);
    ck(2);
    chk("deep_sleep", 32'h0, deep_sleep_state);
    rd("power_control", IDX_POWER_CONTROL, 8'h00, RESP_OKAY);
    external_irq_pin <= 2'h3;
    $display("test blocked power down done");
    wr(IDX_OPTION_SELECT, 8'h40, RESP_OKAY);
    wr(IDX_CLOCK_CONTROL, 8'h03, RESP_OKAY);
    watchdog_enable <= 1'h1;
    wr(IDX_POWER_CONTROL, 8'h02, RESP_OKAY);
    ck(2);
    chk("deep_sleep", 32'h1, deep_sleep_state);
    measure(64);
    chk("timer3_ticks", 32'd8, n_t3);
    chk("watchdog_ticks", 32'd8, n_wd);
    chk("cpu_ticks", 32'd0, n_cpu);
    chk("fast_enable", 32'h0, fast_osc_enable);
    timer3_irq <= 1'h1;
    ck(3);
    chk("deep_sleep", 32'h0, deep_sleep_state);
    timer3_irq <= 1'h0;
    watchdog_enable <= 1'h0;
    $display("test halt done");
    wr(IDX_CLOCK_CONTROL, 8'h23, RESP_OKAY);
    wr(IDX_POWER_CONTROL, 8'h02, RESP_OKAY);
    ck(2);
    chk("deep_sleep", 32'h1, deep_sleep_state);
    chk("slow_enable", 32'h0, slow_osc_enable);
    measure(64);
    chk("timer3_ticks", 32'd0, n_t3);
    chk("watchdog_ticks", 32'd0, n_wd);
    timer3_irq <= 1'h1;
    ck(3);
    chk("deep_sleep", 32'h1, deep_sleep_state);
    timer3_irq <= 1'h0;
    pin_wake <= 1'h1;
    ck(3);
    chk("deep_sleep", 32'h0, deep_sleep_state);
    pin_wake <= 1'h0;
    $display("test stop done");
    ck(20);
    measure(2048);
    chk("timer3_ticks", 32'd2, n_t3);
    wr(IDX_OPTION_SELECT, 8'h00, RESP_OKAY);
    ck(20);
    measure(64);
    chk("timer3_ticks", 32'd8, n_t3);
    $display("test timer3 source done");
    conclude();
  end
endmodule : dcp_clock_power_bench
`default_nettype wire
